// ---- include/vcb_cfg.svh ----
`ifndef VCB_CFG_SVH
`define VCB_CFG_SVH

// Clock and derived timing
`define VCB_CLK_HZ          50000000
`define VCB_RAMP_UNIT_MS    1
`define VCB_MS_CYC          ((`VCB_CLK_HZ / 1000) * `VCB_RAMP_UNIT_MS)

// Command codes
`define VCB_CMD_VOUT_CAL    8'h23
`define VCB_CMD_VOUT_CEIL   8'h24
`define VCB_CMD_MARGIN_HI   8'h25
`define VCB_CMD_MARGIN_LO   8'h26
`define VCB_CMD_SLEW        8'h27
`define VCB_CMD_DROOP       8'h28
`define VCB_CMD_VOUT_FLOOR  8'h2B
`define VCB_CMD_DUTY_CEIL   8'h32
`define VCB_CMD_FSW         8'h33
`define VCB_CMD_VIN_ON      8'h35
`define VCB_CMD_VIN_OFF     8'h36
`define VCB_CMD_PHASE       8'h37
`define VCB_CMD_IOUT_OFS    8'h39
`define VCB_CMD_OV_LIMIT    8'h40

// Register indices
`define VCB_I_CAL     4'h0
`define VCB_I_CEIL    4'h1
`define VCB_I_MHI     4'h2
`define VCB_I_MLO     4'h3
`define VCB_I_SLEW    4'h4
`define VCB_I_DROOP   4'h5
`define VCB_I_FLOOR   4'h6
`define VCB_I_DUTY    4'h7
`define VCB_I_FSW     4'h8
`define VCB_I_VON     4'h9
`define VCB_I_VOFF    4'hA
`define VCB_I_PHASE   4'hB
`define VCB_I_IOFS    4'hC
`define VCB_I_OVL     4'hD
`define VCB_I_NONE    4'hF
`define VCB_NREG      14

// Reset values
`define VCB_RST_ZERO  16'h0000
`define VCB_RST_FULL  16'hFFFF

// Field positions
`define VCB_GRP_HI    11
`define VCB_GRP_LO    8
`define VCB_RAILS_HI  7
`define VCB_RAILS_LO  4
`define VCB_POS_HI    3
`define VCB_POS_LO    0
`define VCB_MODE_HI   7
`define VCB_MODE_LO   5
`define VCB_EXP_HI    4
`define VCB_EXP_LO    0
`define VCB_LEXP_HI   15
`define VCB_LEXP_LO   11
`define VCB_LMAN_HI   10
`define VCB_MODE_LIN  3'h0

// Margin selection codes
`define VCB_MRG_NOM   2'h0
`define VCB_MRG_HI    2'h1
`define VCB_MRG_LO    2'h2

// Fixed-point fractions
`define VCB_FRAC_Q8   8
`define VCB_FRAC_Q16  16
`define VCB_CEIL_NUM  11
`define VCB_CEIL_DEN  10
`define VCB_MV_PER_V  1000

`endif

// ---- include/vcb_pkg.sv ----
`include "vcb_cfg.svh"

package vcb_pkg;

  typedef struct packed {
    logic        [15:0] vin;       // Input voltage, linear
    logic        [15:0] iout;      // Raw output current, linear
    logic        [15:0] vout;      // Measured output voltage, output-voltage mode
  } vcb_meas_t;

  typedef struct packed {
    logic        [15:0] vout_ref;  // Regulation reference, output-voltage mode
    logic        [15:0] duty_q8;   // Duty ceiling, percent Q8.8
    logic        [15:0] fsw_khz;   // Switching frequency, kHz
    logic               conv_on;
    logic        [15:0] phase_frac;
    logic        [3:0]  group_id;
    logic signed [23:0] iout_q8;   // Reported current, A Q16.8
    logic               ov_fault;
    logic               floor_warn;
    logic               mode_bad;
  } vcb_ctl_t;

  typedef struct packed {
    logic [`VCB_NREG-1:0][15:0] regs;
    logic [31:0]                ramp;
    vcb_ctl_t                   ctl;
    logic [15:0]                rdata;
    logic                       rvalid;
    logic                       err;
    logic [15:0]                strap_s1;
    logic [15:0]                strap_s2;
    logic                       sync_s1;
    logic                       sync_s2;
  } vcb_state_t;

endpackage

// ---- rtl/vcb_bank.sv ----
`include "vcb_cfg.svh"

module vcb_bank (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic [7:0]         reg_cmd,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [15:0]        reg_wdata,
  output      logic [15:0]        reg_rdata,
  output      logic               reg_rvalid,
  output      logic               reg_err,
  input  wire logic [15:0]        vout_cmd,
  input  wire logic [15:0]        vout_trim,
  input  wire logic [7:0]         vout_mode,
  input  wire logic [1:0]         margin_sel,
  input  wire vcb_pkg::vcb_meas_t meas,
  input  wire logic               clear_faults,
  input  wire logic [15:0]        strap_vout,
  input  wire logic               sync_pin,
  output      vcb_pkg::vcb_ctl_t  ctl
);

  vcb_pkg::vcb_state_t s_q;
  vcb_pkg::vcb_state_t s_d;

  // Command code to register index
  function automatic logic [3:0] cmd_index(input logic [7:0] c);
    unique case (c)
      `VCB_CMD_VOUT_CAL:   cmd_index = `VCB_I_CAL;
      `VCB_CMD_VOUT_CEIL:  cmd_index = `VCB_I_CEIL;
      `VCB_CMD_MARGIN_HI:  cmd_index = `VCB_I_MHI;
      `VCB_CMD_MARGIN_LO:  cmd_index = `VCB_I_MLO;
      `VCB_CMD_SLEW:       cmd_index = `VCB_I_SLEW;
      `VCB_CMD_DROOP:      cmd_index = `VCB_I_DROOP;
      `VCB_CMD_VOUT_FLOOR: cmd_index = `VCB_I_FLOOR;
      `VCB_CMD_DUTY_CEIL:  cmd_index = `VCB_I_DUTY;
      `VCB_CMD_FSW:        cmd_index = `VCB_I_FSW;
      `VCB_CMD_VIN_ON:     cmd_index = `VCB_I_VON;
      `VCB_CMD_VIN_OFF:    cmd_index = `VCB_I_VOFF;
      `VCB_CMD_PHASE:      cmd_index = `VCB_I_PHASE;
      `VCB_CMD_IOUT_OFS:   cmd_index = `VCB_I_IOFS;
      `VCB_CMD_OV_LIMIT:   cmd_index = `VCB_I_OVL;
      default:             cmd_index = `VCB_I_NONE;
    endcase
  endfunction

  // Linear value scaled by 2^frac
  function automatic logic signed [47:0] lin_val(input logic [15:0] x, input int frac);
    logic signed [47:0] m;
    int                 sh;
    m  = 48'(signed'(x[`VCB_LMAN_HI:0]));
    sh = int'(signed'(x[`VCB_LEXP_HI:`VCB_LEXP_LO])) + frac;
    if (sh >= 0) begin
      lin_val = m <<< sh;
    end else begin
      lin_val = m >>> (-sh);
    end
  endfunction

  // Signed shift by a signed amount
  function automatic logic signed [63:0] shv(input logic signed [63:0] v, input int sh);
    if (sh >= 0) begin
      shv = v <<< sh;
    end else begin
      shv = v >>> (-sh);
    end
  endfunction

  // Clamp a signed value into 16 unsigned bits
  function automatic logic [15:0] sat16(input logic signed [63:0] v);
    if (v < 0) begin
      sat16 = 16'h0000;
    end else if (v > 64'sh0000_0000_0000_FFFF) begin
      sat16 = 16'hFFFF;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  logic [3:0]          wr_idx;
  int                  vexp;
  logic [15:0]         base;
  logic signed [63:0]  req;
  logic [15:0]         ceil_cap;
  logic [15:0]         tgt;
  logic signed [47:0]  step;
  logic signed [63:0]  diff;
  logic signed [63:0]  iout_v;
  logic signed [63:0]  drop;
  logic signed [63:0]  prod;
  logic signed [47:0]  vin_v;
  logic [3:0]          rails;
  logic [3:0]          pos;
  logic [19:0]         phase_num;
  logic [15:0]         wval;

  always_comb begin
    s_d        = s_q;
    wr_idx     = cmd_index(reg_cmd);
    vexp       = int'(signed'(vout_mode[`VCB_EXP_HI:`VCB_EXP_LO]));
    s_d.ctl.mode_bad = vout_mode[`VCB_MODE_HI:`VCB_MODE_LO] != `VCB_MODE_LIN;

    // Pin synchronisers
    s_d.strap_s1 = strap_vout;
    s_d.strap_s2 = s_q.strap_s1;
    s_d.sync_s1  = sync_pin;
    s_d.sync_s2  = s_q.sync_s1;

    // Register writes and reads
    ceil_cap = sat16(64'((32'(s_q.strap_s2) * `VCB_CEIL_NUM) / `VCB_CEIL_DEN));
    wval     = reg_wdata;
    if (wr_idx == `VCB_I_CEIL && reg_wdata > ceil_cap) begin
      wval = ceil_cap;
    end
    s_d.rvalid = 1'b0;
    s_d.err    = 1'b0;
    if (reg_wr) begin
      if (wr_idx == `VCB_I_NONE) begin
        s_d.err = 1'b1;
      end else begin
        s_d.regs[wr_idx] = wval;
      end
    end else if (reg_rd) begin
      s_d.rvalid = 1'b1;
      if (wr_idx == `VCB_I_NONE) begin
        s_d.err   = 1'b1;
        s_d.rdata = 16'h0000;
      end else begin
        s_d.rdata = s_q.regs[wr_idx];
      end
    end

    // Target selection
    unique case (margin_sel)
      `VCB_MRG_HI: base = s_q.regs[`VCB_I_MHI];
      `VCB_MRG_LO: base = s_q.regs[`VCB_I_MLO];
      default:     base = vout_cmd;
    endcase
    req = 64'(base) + 64'(signed'(vout_trim))
        + 64'(signed'(s_q.regs[`VCB_I_CAL]));
    tgt = sat16(req);
    if (tgt > s_q.regs[`VCB_I_CEIL]) begin
      tgt = s_q.regs[`VCB_I_CEIL];
    end
    if (req < signed'(64'(s_q.regs[`VCB_I_FLOOR]))) begin
      tgt = s_q.regs[`VCB_I_FLOOR];
      s_d.ctl.floor_warn = 1'b1;
    end else if (clear_faults) begin
      s_d.ctl.floor_warn = 1'b0;
    end

    // Ramp toward target
    step = lin_val(s_q.regs[`VCB_I_SLEW], `VCB_FRAC_Q16 - vexp) / `VCB_MS_CYC;
    diff = 64'({tgt, 16'h0000}) - 64'(s_q.ramp);
    if (step <= 0 || diff <= 64'(step) && diff >= -64'(step)) begin
      s_d.ramp = {tgt, 16'h0000};
    end else if (diff > 0) begin
      s_d.ramp = s_q.ramp + step[31:0];
    end else begin
      s_d.ramp = s_q.ramp - step[31:0];
    end

    // Current report with offset
    iout_v = 64'(lin_val(meas.iout, `VCB_FRAC_Q8))
           + 64'(lin_val(s_q.regs[`VCB_I_IOFS], `VCB_FRAC_Q8));
    s_d.ctl.iout_q8 = iout_v[23:0];

    // Load line
    prod = 64'(lin_val(s_q.regs[`VCB_I_DROOP], `VCB_FRAC_Q8)) * 64'(s_q.ctl.iout_q8);
    drop = shv(prod, -vexp - `VCB_FRAC_Q16) / `VCB_MV_PER_V;
    if (drop < 0) begin
      drop = 64'sh0;
    end
    s_d.ctl.vout_ref = sat16(64'(s_q.ramp[31:16]) - drop);

    // Duty and frequency
    s_d.ctl.duty_q8 = 16'(lin_val(s_q.regs[`VCB_I_DUTY], `VCB_FRAC_Q8));
    s_d.ctl.fsw_khz = 16'(lin_val(s_q.regs[`VCB_I_FSW], 0));

    // Input hysteresis
    vin_v = lin_val(meas.vin, `VCB_FRAC_Q8);
    if (!s_q.ctl.conv_on && vin_v >= lin_val(s_q.regs[`VCB_I_VON], `VCB_FRAC_Q8)) begin
      s_d.ctl.conv_on = 1'b1;
    end else if (s_q.ctl.conv_on && vin_v <= lin_val(s_q.regs[`VCB_I_VOFF], `VCB_FRAC_Q8)) begin
      s_d.ctl.conv_on = 1'b0;
    end

    // Phase spreading
    s_d.ctl.group_id = s_q.regs[`VCB_I_PHASE][`VCB_GRP_HI:`VCB_GRP_LO];
    rails     = s_q.regs[`VCB_I_PHASE][`VCB_RAILS_HI:`VCB_RAILS_LO];
    pos       = s_q.regs[`VCB_I_PHASE][`VCB_POS_HI:`VCB_POS_LO];
    phase_num = {pos, 16'h0000};
    if (s_q.sync_s2 && rails != 4'h0 && pos < rails) begin
      s_d.ctl.phase_frac = 16'(phase_num / 20'(rails));
    end else begin
      s_d.ctl.phase_frac = 16'h0000;
    end

    // Over-voltage fault, set wins over clear
    if (meas.vout > s_q.regs[`VCB_I_OVL]) begin
      s_d.ctl.ov_fault = 1'b1;
    end else if (clear_faults) begin
      s_d.ctl.ov_fault = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q                       <= '0;
      s_q.regs[`VCB_I_CEIL]     <= `VCB_RST_FULL;
      s_q.regs[`VCB_I_OVL]      <= `VCB_RST_FULL;
      s_q.regs[`VCB_I_VON]      <= `VCB_RST_FULL;
      s_q.regs[`VCB_I_CAL]      <= `VCB_RST_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata  = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign reg_err    = s_q.err;
  assign ctl        = s_q.ctl;

endmodule // vcb_bank

// ---- verification/vcb_bank_checker.sv ----
module vcb_bank_checker (
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic               reg_rvalid,
  input wire logic               reg_err,
  input wire logic               clear_faults,
  input wire logic               sync_pin,
  input wire logic [7:0]         reg_cmd,
  input wire logic [7:0]         vout_mode,
  input wire logic [15:0]        reg_wdata,
  input wire logic [15:0]        reg_rdata,
  input wire logic [15:0]        vout_cmd,
  input wire logic [15:0]        vout_trim,
  input wire logic [15:0]        strap_vout,
  input wire logic [1:0]         margin_sel,
  input wire vcb_pkg::vcb_meas_t meas,
  input wire vcb_pkg::vcb_ctl_t  ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wr_hi; reg_wr && reg_cmd == 8'h25; endsequence
  sequence s_rd_hi; reg_rd && !reg_wr && reg_cmd == 8'h25; endsequence
  property p_readback; s_wr_hi ##2 s_rd_hi |=> reg_rdata == $past(reg_wdata, 3); endproperty
  property p_rvalid; reg_rd && !reg_wr |=> reg_rvalid; endproperty
  property p_no_rvalid; !(reg_rd && !reg_wr) |=> !reg_rvalid; endproperty
  property p_err; (reg_wr || reg_rd) && reg_cmd == 8'h30 |=> reg_err; endproperty
  property p_ov_hold; ctl.ov_fault && !clear_faults |=> ctl.ov_fault; endproperty
  property p_warn_hold; ctl.floor_warn && !clear_faults |=> ctl.floor_warn; endproperty
  property p_mode_bad; vout_mode[7:5] != 3'h0 |=> ctl.mode_bad; endproperty
  property p_mode_ok; vout_mode[7:5] == 3'h0 |=> !ctl.mode_bad; endproperty
  property p_phase; !sync_pin [*5] |=> ctl.phase_frac == 16'h0000; endproperty
  a_readback: assert property (p_readback) else $error("readback differs");
  a_rvalid: assert property (p_rvalid) else $error("no read valid");
  a_no_rvalid: assert property (p_no_rvalid) else $error("stray read valid");
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  a_ov_hold: assert property (p_ov_hold) else $error("fault dropped");
  a_warn_hold: assert property (p_warn_hold) else $error("warning dropped");
  a_mode_bad: assert property (p_mode_bad) else $error("bad mode not flagged");
  a_mode_ok: assert property (p_mode_ok) else $error("linear mode flagged");
  a_phase: assert property (p_phase) else $error("phase without sync");
endmodule // vcb_bank_checker

// ---- verification/vcb_host_model.sv ----
module vcb_host_model (
  input  wire logic        clk_sys,
  input  wire logic        reg_rvalid,
  input  wire logic        reg_err,
  input  wire logic [15:0] reg_rdata,
  output logic      [7:0]  reg_cmd,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_cmd = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One strobe cycle, then released data lines show the inverse
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                     output logic [15:0] q, output logic e);
    @(posedge clk_sys);
    reg_cmd <= c;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= ~d;
    #1;
    q = reg_rdata;
    e = reg_err;
  endtask
endmodule // vcb_host_model

// ---- verification/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  wire logic [7:0]    reg_cmd;
  wire logic          reg_wr, reg_rd;
  wire logic [15:0]   reg_wdata;
  logic [15:0]        reg_rdata, vout_cmd, vout_trim, strap_vout, q, d, c;
  logic               reg_rvalid, reg_err, clear_faults, sync_pin, e;
  logic [7:0]         vout_mode;
  logic [1:0]         margin_sel;
  vcb_pkg::vcb_meas_t meas;
  vcb_pkg::vcb_ctl_t  ctl;
  int                 mismatches = 0, n_tests = 0, seed = 26, i;
  logic [7:0]  cmds [14] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2B,
                             8'h32, 8'h33, 8'h35, 8'h36, 8'h37, 8'h39, 8'h40};
  logic [23:0] cfg [13] = '{24'h230000, 24'h270000, 24'h280000, 24'h2B0000, 24'h253000,
                            24'h261000, 24'h32005A, 24'h330190, 24'h350028, 24'h360023,
                            24'h370741, 24'h390002, 24'h407000};
  always #10 clk_sys = ~clk_sys;
  vcb_host_model host (.clk_sys(clk_sys), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
    .reg_rdata(reg_rdata), .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  vcb_bank DUT (.clk_sys(clk_sys), .rst_n(rst_n), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_err(reg_err), .vout_cmd(vout_cmd), .vout_trim(vout_trim), .vout_mode(vout_mode),
    .margin_sel(margin_sel), .meas(meas), .clear_faults(clear_faults),
    .strap_vout(strap_vout), .sync_pin(sync_pin), .ctl(ctl));
  function automatic logic [15:0] exp_ref(input logic [1:0] s, input logic [15:0] v, f);
    logic [15:0] b;
    b = (s == 2'h1) ? 16'h3000 : (s == 2'h2) ? 16'h1000 : v;
    return (b < f) ? f : b;
  endfunction
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] x);
    n_tests++;
    if (s !== x) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic drive(input logic [15:0] v, input logic [1:0] s, input int n);
    @(posedge clk_sys);
    vout_cmd <= v;
    margin_sel <= s;
    wt(n);
  endtask
  initial begin
    {vout_cmd, vout_trim, margin_sel, meas, clear_faults} = '0;
    {vout_mode, strap_vout, sync_pin} = {8'h15, 16'h1900, 1'b1};
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 14; i++) if (i != 1) begin
      d = 16'($random(seed));
      host.acc(1'b1, cmds[i], d, q, e);
      host.acc(1'b0, cmds[i], 16'h0000, q, e);
      chk("readback", q, d);
      chk("rvalid", reg_rvalid, 1'b1);
    end
    host.acc(1'b0, 8'h30, 16'h0000, q, e);
    chk("unmapped_err", e, 1'b1);
    chk("unmapped_rd", q, 16'h0000);
    $display("register test done");
    for (i = 0; i < 13; i++) host.acc(1'b1, cfg[i][23:16], cfg[i][15:0], q, e);
    @(posedge clk_sys);
    clear_faults <= 1'b1;
    wt(2);
    clear_faults <= 1'b0;
    for (i = 0; i < 8; i++) begin
      c = 16'($random(seed)) & 16'h7FFF;
      drive(c, i[1:0], 4);
      chk("vout_ref", ctl.vout_ref, exp_ref(i[1:0], c, 16'h0000));
    end
    host.acc(1'b1, 8'h2B, 16'h2000, q, e);
    drive(16'h0800, 2'h2, 4);
    chk("floor_ref", ctl.vout_ref, exp_ref(2'h2, 16'h0800, 16'h2000));
    chk("floor_warn", ctl.floor_warn, 1'b1);
    chk("no_fault", ctl.ov_fault, 1'b0);
    host.acc(1'b1, 8'h2B, 16'h0000, q, e);
    host.acc(1'b1, 8'h23, 16'h0010, q, e);
    vout_trim <= 16'hFFF8;
    drive(16'h0800, 2'h0, 4);
    chk("cal_ref", ctl.vout_ref, 16'h0808);
    host.acc(1'b1, 8'h23, 16'h0000, q, e);
    vout_trim <= 16'h0000;
    $display("target test done");
    chk("duty", ctl.duty_q8, 16'h5A00);
    chk("fsw", ctl.fsw_khz, 16'h0190);
    chk("group", ctl.group_id, 4'h7);
    chk("phase", ctl.phase_frac, 16'h4000);
    @(posedge clk_sys);
    meas <= '{vin: 16'h0030, iout: 16'h000A, vout: 16'h7001};
    wt(3);
    chk("iout", ctl.iout_q8, 24'h000C00);
    chk("conv_on", ctl.conv_on, 1'b1);
    chk("ov_set", ctl.ov_fault, 1'b1);
    meas <= '{vin: 16'h0024, iout: 16'h000A, vout: 16'h0000};
    clear_faults <= 1'b1;
    wt(3);
    chk("conv_hold", ctl.conv_on, 1'b1);
    chk("ov_clear", ctl.ov_fault, 1'b0);
    chk("warn_clear", ctl.floor_warn, 1'b0);
    meas.vin <= 16'h0020;
    clear_faults <= 1'b0;
    vout_mode <= 8'h35;
    wt(3);
    chk("conv_off", ctl.conv_on, 1'b0);
    chk("mode_bad", ctl.mode_bad, 1'b1);
    vout_mode <= 8'h15;
    sync_pin <= 1'b0;
    wt(8);
    chk("phase_nosync", ctl.phase_frac, 16'h0000);
    $display("control test done");
    host.acc(1'b1, 8'h28, 16'h007D, q, e);
    drive(16'h3000, 2'h0, 4);
    chk("droop_ref", ctl.vout_ref, 16'h3000 - 16'(125 * 12 * 2048 / 1000));
    host.acc(1'b1, 8'h28, 16'h0000, q, e);
    host.acc(1'b1, 8'h27, 16'h03E8, q, e);
    drive(16'h3800, 2'h0, 26);
    chk("slew_mid", ctl.vout_ref inside {[16'h33F0:16'h3400]}, 1'b1);
    wt(40);
    chk("slew_end", ctl.vout_ref, 16'h3800);
    host.acc(1'b1, 8'h27, 16'h0000, q, e);
    $display("ramp test done");
    host.acc(1'b1, 8'h24, 16'hFFFF, q, e);
    host.acc(1'b0, 8'h24, 16'h0000, q, e);
    chk("ceiling_cap", q, 16'h1900 * 11 / 10);
    drive(16'h7000, 2'h0, 4);
    chk("ceiling_ref", ctl.vout_ref, 16'h1B80);
    $display("ceiling test done");
    close_out();
  end
  initial begin
    #1000000;
    mismatches++;
    close_out();
  end
endmodule // testbench
bind vcb_bank vcb_bank_checker chk (.*);
